// ---- hdl/rfs_top.sv ----
// Operation
// - bit 15 set when head frame is complete and its status valid
// - bit 15 clear while nothing pending or frame still arriving
// - bit 7 set for broadcast destination
// - bit 6 set for group destination, broadcast included
// - bit 5 set for unicast destination
// - bit 4 set on symbol error during reception
// - bit 3 set when length/type exceeds 1500 and the frame is not a runt, clear otherwise
// - frame type bit meaningless for runt frames
// - bit 2 set when frame length exceeds 1916 bytes
// - too-long counts as bad; frame kept whole only with pass-bad
// - bit 1 set for collision
// - bit 0 set on frame check sequence mismatch
// - bad frames kept only when pass-bad control bit 9 is set
// - status register mirrors head frame status word
// - byte count register mirrors bits 10-0, bits 15-11 zero
//
// The AHB-Lite register port is this design's own decision.

module rfs_top
    import rfs_pkg::*;
#(
    parameter int MAX_LEN = RFS_MAX_LEN,
    parameter int TYPE_LIMIT = RFS_TYPE_LIMIT
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rx_start,
    input wire logic rx_done,
    input wire rfs_frame_s rx_frame,
    input wire logic head_release,
    output logic frame_store,
    output logic frame_drop,
    output logic irq
);
    // ========================================================
    // parameter checks
    localparam int COUNT_RANGE = 1 << RFS_COUNT_W;
    localparam int TYPE_RANGE = 1 << 16;
    localparam logic [10:0] MAX_LEN_W = MAX_LEN[10:0];
    localparam logic [15:0] TYPE_LIMIT_W = TYPE_LIMIT[15:0];

    generate
        if (MAX_LEN < 1 || MAX_LEN >= COUNT_RANGE) begin : g_max_len_check
            $error("MAX_LEN must fit the byte count field");
        end
        if (TYPE_LIMIT < 0 || TYPE_LIMIT >= TYPE_RANGE - 1) begin : g_type_limit_check
            $error("TYPE_LIMIT must fit the length/type field");
        end
    endgenerate

    // ========================================================
    // head of receive queue states
    typedef enum {
        RFS_HEAD_EMPTY,
        RFS_HEAD_FULL
    } rfs_head_e;

    // ========================================================
    // destination address class
    function automatic logic rfs_is_broadcast(input logic [47:0] da);
        return &da;
    endfunction

    function automatic logic rfs_is_group(input logic [47:0] da);
        return da[40];
    endfunction

    // ========================================================
    // length and type checks
    function automatic logic rfs_is_type_frame(input logic [15:0] len_type);
        return len_type > TYPE_LIMIT_W;
    endfunction

    function automatic logic rfs_frame_type_flag(input logic [15:0] len_type, input logic runt);
        return rfs_is_type_frame(len_type) & ~runt;
    endfunction

    function automatic logic rfs_is_too_long(input logic [10:0] count);
        return count > MAX_LEN_W;
    endfunction

    // ========================================================
    // status word builder
    function automatic logic [15:0] rfs_status_word(input rfs_frame_s f);
        logic [15:0] w;
        logic runt;
        w = 16'h0000;
        runt = f.collision;
        w[RFS_BIT_BCAST] = rfs_is_broadcast(f.dest_addr);
        w[RFS_BIT_GROUP] = rfs_is_group(f.dest_addr);
        w[RFS_BIT_INDIV] = ~rfs_is_group(f.dest_addr);
        w[RFS_BIT_SYMERR] = f.symbol_error;
        w[RFS_BIT_FTYPE] = rfs_frame_type_flag(f.len_type, runt);
        w[RFS_BIT_TOOLONG] = rfs_is_too_long(f.byte_count);
        w[RFS_BIT_RUNT] = runt;
        w[RFS_BIT_CRC] = f.crc_bad;
        return w;
    endfunction

    function automatic logic rfs_is_bad(input logic [15:0] w);
        return w[RFS_BIT_TOOLONG] | w[RFS_BIT_RUNT] | w[RFS_BIT_CRC];
    endfunction

    // ========================================================
    // bus helpers
    function automatic logic rfs_addr_hit(input logic [9:0] addr, input logic [9:0] target);
        return addr == target;
    endfunction

    function automatic logic [1:0] rfs_w1c(input logic [1:0] old, input logic [1:0] clr, input logic [1:0] set);
        return (old & ~clr) | set;
    endfunction

    function automatic logic [15:0] rfs_status_view(input logic valid, input logic [15:0] status);
        return {valid, 7'h00, status[7:0]};
    endfunction

    // ========================================================
    // state
    rfs_head_e head_state;
    logic receiving;
    logic [15:0] head_status;
    logic [10:0] head_count;
    logic [15:0] control;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic wr_pend;
    logic [9:0] wr_addr;

    // ========================================================
    // frame classification
    logic head_full;
    logic head_free;
    logic [15:0] new_status;
    logic new_bad;
    logic accept;
    logic reject;
    logic load_head;
    logic [1:0] ev;

    assign head_full = (head_state == RFS_HEAD_FULL);
    assign head_free = ~head_full;
    assign new_status = rfs_status_word(rx_frame);
    assign new_bad = rfs_is_bad(new_status);
    assign accept = rx_done & (~new_bad | control[RFS_BIT_PASS_BAD]);
    assign reject = rx_done & ~accept;
    assign load_head = head_free & accept;
    assign ev[RFS_IRQ_FRAME] = load_head;
    assign ev[RFS_IRQ_DROP] = reject;

    // ========================================================
    // bus decode
    logic rd_req;
    logic wr_req;
    logic wr_control;
    logic wr_mask;
    logic wr_irq_status;
    logic [1:0] wr_clear;

    assign rd_req = hsel & hready & ~hwrite & (htrans == RFS_HTRANS_NONSEQ);
    assign wr_req = hsel & hready & hwrite & (htrans == RFS_HTRANS_NONSEQ);
    assign wr_control = wr_pend & rfs_addr_hit(wr_addr, RFS_ADDR_CONTROL);
    assign wr_mask = wr_pend & rfs_addr_hit(wr_addr, RFS_ADDR_IRQ_MASK);
    assign wr_irq_status = wr_pend & rfs_addr_hit(wr_addr, RFS_ADDR_IRQ_STATUS);
    assign wr_clear = wr_irq_status ? hwdata[1:0] : 2'b00;

    // ========================================================
    // read words
    logic [31:0] rd_status_word;
    logic [31:0] rd_count_word;
    logic [31:0] rd_control_word;
    logic [31:0] rd_irq_status_word;
    logic [31:0] rd_mask_word;
    logic [31:0] next_hrdata;

    assign rd_status_word = {16'h0000, rfs_status_view(head_full & ~receiving, head_status)};
    assign rd_count_word = {21'h000000, head_count};
    assign rd_control_word = {16'h0000, control};
    assign rd_irq_status_word = {30'h00000000, irq_status};
    assign rd_mask_word = {30'h00000000, irq_mask};

    // ========================================================
    // frame reception window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            receiving <= 1'b0;
        end else if (rx_start) begin
            receiving <= 1'b1;
        end else if (rx_done) begin
            receiving <= 1'b0;
        end
    end

    // ========================================================
    // head of receive queue
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_state <= RFS_HEAD_EMPTY;
        end else begin
            unique case (head_state)
                RFS_HEAD_EMPTY: begin
                    if (accept) begin
                        head_state <= RFS_HEAD_FULL;
                    end
                end
                RFS_HEAD_FULL: begin
                    if (head_release) begin
                        head_state <= RFS_HEAD_EMPTY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_status <= 16'h0000;
        end else if (load_head) begin
            head_status <= new_status;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            head_count <= 11'h000;
        end else if (load_head) begin
            head_count <= rx_frame.byte_count;
        end
    end

    // ========================================================
    // frame disposal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_store <= 1'b0;
        end else begin
            frame_store <= accept;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_drop <= 1'b0;
        end else begin
            frame_drop <= reject;
        end
    end

    // ========================================================
    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
        end else begin
            wr_pend <= wr_req;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr <= 10'h000;
        end else begin
            wr_addr <= haddr[9:0];
        end
    end

    // ========================================================
    // control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= RFS_CONTROL_RST;
        end else if (wr_control) begin
            control <= hwdata[15:0];
        end
    end

    // ========================================================
    // interrupt mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= RFS_IRQ_RST;
        end else if (wr_mask) begin
            irq_mask <= hwdata[1:0];
        end
    end

    // ========================================================
    // interrupt status, set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= RFS_IRQ_RST;
        end else begin
            irq_status <= rfs_w1c(irq_status, wr_clear, ev);
        end
    end

    // ========================================================
    // read data; status and byte count have no write path
    always_comb begin
        next_hrdata = hrdata;
        if (rd_req) begin
            unique case (haddr[9:0])
                RFS_ADDR_STATUS: begin
                    next_hrdata = rd_status_word;
                end
                RFS_ADDR_BYTE_COUNT: begin
                    next_hrdata = rd_count_word;
                end
                RFS_ADDR_CONTROL: begin
                    next_hrdata = rd_control_word;
                end
                RFS_ADDR_IRQ_STATUS: begin
                    next_hrdata = rd_irq_status_word;
                end
                RFS_ADDR_IRQ_MASK: begin
                    next_hrdata = rd_mask_word;
                end
                default: begin
                    next_hrdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // ========================================================
    // bus response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ========================================================
    // interrupt output
    logic irq_pending;
    assign irq_pending = |(irq_status & irq_mask);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_pending;
        end
    end
endmodule

// ---- common/rfs_pkg.sv ----
package rfs_pkg;
    // ========================================================
    // register map (printed offsets not all multiples of four: kept as indices)
    localparam logic [7:0] RFS_IDX_STATUS = 8'h04;
    localparam logic [7:0] RFS_IDX_BYTE_COUNT = 8'h06;
    localparam logic [7:0] RFS_IDX_CONTROL = 8'h08;
    localparam logic [7:0] RFS_IDX_IRQ_STATUS = 8'h09;
    localparam logic [7:0] RFS_IDX_IRQ_MASK = 8'h0a;
    localparam logic [9:0] RFS_ADDR_STATUS = {RFS_IDX_STATUS, 2'b00};
    localparam logic [9:0] RFS_ADDR_BYTE_COUNT = {RFS_IDX_BYTE_COUNT, 2'b00};
    localparam logic [9:0] RFS_ADDR_CONTROL = {RFS_IDX_CONTROL, 2'b00};
    localparam logic [9:0] RFS_ADDR_IRQ_STATUS = {RFS_IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] RFS_ADDR_IRQ_MASK = {RFS_IDX_IRQ_MASK, 2'b00};
    // ========================================================
    // field positions
    localparam int RFS_BIT_VALID = 15;
    localparam int RFS_BIT_BCAST = 7;
    localparam int RFS_BIT_GROUP = 6;
    localparam int RFS_BIT_INDIV = 5;
    localparam int RFS_BIT_SYMERR = 4;
    localparam int RFS_BIT_FTYPE = 3;
    localparam int RFS_BIT_TOOLONG = 2;
    localparam int RFS_BIT_RUNT = 1;
    localparam int RFS_BIT_CRC = 0;
    localparam int RFS_BIT_PASS_BAD = 9;
    localparam int RFS_IRQ_FRAME = 0;
    localparam int RFS_IRQ_DROP = 1;
    localparam int RFS_COUNT_W = 11;
    // ========================================================
    // limits and reset values
    localparam logic [15:0] RFS_TYPE_LIMIT = 16'h05dc;
    localparam logic [10:0] RFS_MAX_LEN = 11'h77c;
    localparam logic [15:0] RFS_CONTROL_RST = 16'h0000;
    localparam logic [1:0] RFS_IRQ_RST = 2'h0;
    localparam logic [1:0] RFS_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [47:0] dest_addr;
        logic [15:0] len_type;
        logic [10:0] byte_count;
        logic symbol_error;
        logic collision;
        logic crc_bad;
    } rfs_frame_s;
endpackage

// ---- sim/rfs_mac_model.sv ----
module rfs_mac_model
    import rfs_pkg::*;
(
    input wire logic hclk,
    input wire logic go,
    input wire rfs_frame_s f,
    output logic rx_start,
    output logic rx_done,
    output rfs_frame_s rx_frame
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==============================
    // frame arrives over two cycles; struct is garbage outside rx_done
    initial begin
        rx_start = 0;
        rx_done = 0;
        rx_frame = '0;
    end
    always @(posedge hclk) begin
        rx_start <= go;
        rx_done <= rx_start;
        rx_frame <= rx_start ? f : ~f;
    end
endmodule

// ---- sim/rfs_top_properties.sv ----
module rfs_top_properties
    import rfs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic rx_done,
    input wire rfs_frame_s rx_frame,
    input wire logic frame_store,
    input wire logic frame_drop
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic bad;
    assign bad = rx_frame.collision | rx_frame.crc_bad | (rx_frame.byte_count > RFS_MAX_LEN);
    sequence s_good;
        rx_done && !bad;
    endsequence
    property p_rdy; hreadyout && !hresp; endproperty
    a_rdy: assert property (p_rdy) else $error("bus not ready or error");
    property p_good; s_good |=> frame_store && !frame_drop; endproperty
    a_good: assert property (p_good) else $error("good frame not stored");
    property p_one; rx_done |=> frame_store != frame_drop; endproperty
    a_one: assert property (p_one) else $error("frame neither or both");
    property p_idle; !rx_done |=> !frame_store && !frame_drop; endproperty
    a_idle: assert property (p_idle) else $error("spurious store or drop");
    property p_dropbad; frame_drop |-> $past(bad); endproperty
    a_dropbad: assert property (p_dropbad) else $error("good frame dropped");
    property p_long; rx_done && rx_frame.byte_count > RFS_MAX_LEN |=> frame_store || frame_drop; endproperty
    a_long: assert property (p_long) else $error("long frame lost");
    property p_storesrc; frame_store |-> $past(rx_done); endproperty
    a_storesrc: assert property (p_storesrc) else $error("store without frame");
    property p_pulse; frame_store |=> !frame_store; endproperty
    a_pulse: assert property (p_pulse) else $error("store not a pulse");
endmodule
bind rfs_top rfs_top_properties rfs_top_properties_i (.hclk, .hresetn, .hreadyout, .hresp, .rx_done, .rx_frame,
    .frame_store, .frame_drop);

// ---- sim/tb.sv ----
module tb;
    import rfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, head_release = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic hready, hreadyout, hresp, rx_start, rx_done, frame_store, frame_drop, irq;
    rfs_frame_s f = '0, rx_frame;
    int n_errors = 0, check_count = 0;
    assign hready = hreadyout;
    rfs_top rfs_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .rx_start, .rx_done, .rx_frame, .head_release, .frame_store, .frame_drop, .irq);
    rfs_mac_model rfs_mac_model_i (.hclk, .go, .f, .rx_start, .rx_done, .rx_frame);
    initial begin
        forever #25 hclk = ~hclk;
    end
    // ==============================
    // bus and compare
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1; htrans <= RFS_HTRANS_NONSEQ; hwrite <= w; haddr <= {22'h0, a}; hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic fc(input rfs_frame_s x, input logic [15:0] es, input logic st);
        logic [31:0] q;
        @(posedge hclk); f <= x; go <= 1;
        @(posedge hclk); go <= 0;
        repeat (4) @(posedge hclk);
        bus(0, RFS_ADDR_STATUS, 0, q);
        chk("status", {16'h0, es}, q);
        if (st) begin
            bus(0, RFS_ADDR_BYTE_COUNT, 0, q);
            chk("count", {21'h0, x.byte_count}, q);
            chk("irq", 1, irq);
            bus(1, RFS_ADDR_IRQ_STATUS, 32'h1, q);
            bus(0, RFS_ADDR_IRQ_STATUS, 0, q);
            chk("irq clear", 0, {q[0], irq});
            @(posedge hclk); head_release <= 1;
            @(posedge hclk); head_release <= 0;
        end
    endtask
    // ==============================
    // scenarios
    task automatic s_regs;
        logic [31:0] q;
        bus(1, RFS_ADDR_STATUS, 32'hffff, q);
        bus(0, RFS_ADDR_STATUS, 0, q);
        chk("empty status", 0, q);
        bus(0, RFS_ADDR_CONTROL, 0, q);
        chk("control", {16'h0, RFS_CONTROL_RST}, q);
        bus(0, RFS_ADDR_IRQ_MASK, 0, q);
        chk("mask", {30'h0, RFS_IRQ_RST}, q);
        bus(0, 10'h3fc, 0, q);
        chk("unmapped", 0, q);
    endtask
    task automatic s_frames;
        logic [31:0] q;
        bus(1, RFS_ADDR_IRQ_MASK, 32'h1, q);
        fc('{48'hffff_ffff_ffff, 16'h0800, 11'h040, 0, 0, 0}, 16'h80c8, 1);
        bus(1, RFS_ADDR_CONTROL, 32'h200, q);
        fc('{48'h0000_1122_3344, 16'h05dc, 11'h7ff, 1, 0, 1}, 16'h8035, 1);
        fc('{48'h0100_0000_0000, 16'h0800, 11'h020, 0, 1, 0}, 16'h8042, 1);
        bus(1, RFS_ADDR_CONTROL, 32'h0, q);
        // dropped frame: valid stays clear, low bits still hold the last head frame
        fc('{48'h0000_0000_0001, 16'h0800, 11'h040, 0, 0, 1}, 16'h0042, 0);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        print_verdict;
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        s_regs;
        s_frames;
        print_verdict;
    end
endmodule
